/* include/conv_params.svh */
// offsets, field positions, codes, masks and counts for the convolver
`ifndef CONV_PARAMS_SVH
`define CONV_PARAMS_SVH
`define LINE_LEN     64
`define PTR_W        6
`define PTR_MAX      6'h3f
`define CFG_N        16
`define IDX_CTRL     4'h9
`define IDX_GAIN     4'ha
`define IDX_THR_LO   4'hb
`define IDX_THR_HI   4'hc
`define IDX_DELAY    4'hd
`define IDX_STATUS   6'h10
`define CTRL_PIX16   0
`define CTRL_SEC_OUT 1
`define CTRL_INTER   2
`define CTRL_FLD_HI  5
`define CTRL_FLD_LO  4
`define FIELD_A      2'h1
`define FIELD_B      2'h2
`define FIELD_AUTO   2'h3
`define LOAD_LAST    7'h47
`define DEV_LAST     4'hf
`define STRB_LAST    3'h2
`define VSYNC_PIX    8'h20
`define INIT_LAST    2'h3
`define BUS_ADDR_OE  16'h7f00
`define BUS_DATA_OE  16'h00ff
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

/* include/conv_pkg.sv */
// types shared by the convolver and its bench
`include "conv_params.svh"
package conv_pkg;
	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} axi_req_t;
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_rsp_t;
	typedef struct packed {
		logic [7:0]  pixel_in_primary;
		logic [7:0]  pixel_io_secondary;
		logic        bypass;
		logic        line_sync_reset;
		logic [15:0] coef_expansion_bus;
		logic        reg_update_flag_strobe_in;
		logic        data_strobe_n;
		logic        chip_enable_n;
		logic        read_write;
		logic        reg_update_flag;
		logic        output_drive_enable_n;
		logic        single_n;
		logic        master_n;
	} pins_in_t;
	typedef struct packed {
		logic [15:0] result_out;
		logic        result_oe;
		logic        result_half_lo;
		logic        threshold_flag;
		logic        gain_saturation_flag;
		logic        delayed_sync_out;
		logic [1:0]  field_select_out;
		logic        reg_update_flag_strobe_out;
		logic        data_strobe_n;
		logic        data_strobe_oe;
		logic        reg_update_flag;
		logic        reg_update_oe;
		logic [15:0] coef_expansion_bus;
		logic [15:0] coef_expansion_oe;
		logic [7:0]  pixel_io_secondary;
		logic        pixel_io_secondary_oe;
		logic [3:0]  device_select_addr;
	} pins_out_t;
	typedef enum logic [3:0] {
		LD_IDLE = 4'h1,
		LD_ADDR = 4'h2,
		LD_STRB = 4'h4,
		LD_NEXT = 4'h8
	} load_st_t;
	typedef struct packed {
		pins_in_t                          s1;
		pins_in_t                          s2;
		logic [1:0]                        init;
		logic                              strap_ok;
		logic                              single;
		logic                              master;
		logic                              eprom;
		logic                              phase;
		logic [`LINE_LEN-1:0][15:0]        ram_a;
		logic [`LINE_LEN-1:0][15:0]        ram_b;
		logic [`PTR_W-1:0]                 ptr;
		logic [2:0][2:0][15:0]             win;
		logic [15:0]                       exp_hi;
		logic [31:0]                       expn;
		logic [31:0]                       sum;
		logic [15:0]                       dly;
		logic [7:0]                        sync_len;
		logic                              field;
		logic                              ds_prev;
		logic                              ce_prev;
		logic [`CFG_N-1:0][7:0]            cfg;
		load_st_t                          lst;
		logic [6:0]                        laddr;
		logic [3:0]                        dev;
		logic [2:0]                        lcnt;
		logic                              aw_have;
		logic                              w_have;
		logic [7:0]                        awaddr;
		logic [7:0]                        wbyte;
		logic                              wlane;
		axi_rsp_t                          rsp;
		pins_out_t                         po;
	} state_t;
endpackage : conv_pkg

/* rtl/image_convolver_interface.sv */
// two-dimensional image convolver with pin loader and axi4-lite registers
// Overview of operation
// - primary bus feeds line delay; msb in 16-bit
// - secondary bus feeds group two, or outputs
// - bypass input skips first line delay
// - line sync high holds delay pointers reset
// - eprom master drives coefficient address, slave takes expansion
// - result scaled 16-bit or muxed 32-bit halves
// - eprom master emits programming strobe, all others pass it
// - strobe input ends master eprom write strobe
// - delayed sync follows line sync, programmed delay
// - eprom master drives data strobe to others
// - pin access needs chip enable, strobe, direction
// - eprom load uses 72 addresses; enable reloads
// - eprom master drives update flag while loading
// - rising edges only, expansion low half included
// - threshold flag high when result exceeds threshold
// - gain saturation flag marks gain overflow
// - active-low power-on reset initialises everything
// - result drivers enabled only by drive enable
// - master outputs four-bit device select address
// - field outputs report auto field, control coding
// - weighted window sum, one result per pixel
// - secondary bus starts as input after reset
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "conv_params.svh"
module image_convolver_interface (
	// clock and reset
	input  wire logic                aclk,
	input  wire logic                aresetn,
	// register bus
	input  wire conv_pkg::axi_req_t  axi_req,
	output var  conv_pkg::axi_rsp_t  axi_rsp,
	// device pins
	input  wire conv_pkg::pins_in_t  pins_in,
	output var  conv_pkg::pins_out_t pins_out
);
	import conv_pkg::*;

	state_t             q;
	state_t             d;
	pins_in_t           p;
	logic               pix_en;
	logic               c16;
	logic               cso;
	logic [15:0]        line0;
	logic [15:0]        line1;
	logic [15:0]        in_b;
	logic [16:0]        op;
	logic signed [31:0] prod;
	logic signed [31:0] acc;
	logic [63:0]        wide;
	logic               ovf;
	logic [15:0]        scaled;
	logic [15:0]        thr;
	logic               host_sel;
	logic [6:0]         haddr;
	logic               start;
	logic               strb_end;
	logic [5:0]         ridx;
	logic [5:0]         widx;

	assign axi_rsp  = q.rsp;
	assign pins_out = q.po;

	// next state of the whole block
	always_comb begin
		d        = q;
		p        = q.s2;
		pix_en   = q.phase;
		c16      = q.cfg[`IDX_CTRL][`CTRL_PIX16];
		cso      = q.cfg[`IDX_CTRL][`CTRL_SEC_OUT];
		line0    = '0;
		line1    = '0;
		in_b     = '0;
		op       = '0;
		prod     = '0;
		acc      = '0;
		wide     = '0;
		ovf      = 1'b0;
		scaled   = '0;
		thr      = {q.cfg[`IDX_THR_HI], q.cfg[`IDX_THR_LO]};
		host_sel = 1'b0;
		haddr    = p.coef_expansion_bus[14:8];
		start    = 1'b0;
		strb_end = 1'b0;
		ridx     = q.rsp.rvalid ? 6'h00 : axi_req.araddr[7:2];
		widx     = q.awaddr[7:2];

		// pin synchronisers, two stages
		d.s1 = pins_in;
		d.s2 = q.s1;
		d.phase = ~q.phase;

		// straps and the bus top bit are caught once after reset
		if (!q.strap_ok) begin
			d.init = q.init + 2'h1;
			if (q.init == `INIT_LAST) begin
				d.strap_ok = 1'b1;
				d.single   = ~p.single_n;
				d.master   = ~p.master_n & p.single_n;
				d.eprom    = p.coef_expansion_bus[15] & (~p.single_n | ~p.master_n);
				start      = p.coef_expansion_bus[15] & (~p.single_n | ~p.master_n);
			end
		end

		// pixel formation and line delays
		line0 = c16 ? {p.pixel_in_primary, p.pixel_io_secondary}
		            : {8'h00, p.pixel_in_primary};
		line1 = p.bypass ? line0 : q.ram_a[q.ptr];
		in_b  = (c16 || cso) ? line1
		                     : {8'h00, p.pixel_io_secondary};
		if (pix_en) begin
			if (p.line_sync_reset) begin
				d.ptr = '0;
			end else if (q.ptr != `PTR_MAX) begin
				d.ram_a[q.ptr] = line0;
				d.ram_b[q.ptr] = in_b;
				d.ptr = q.ptr + 1'b1;
			end
			for (int r = 0; r < 3; r++) begin
				d.win[r][2] = q.win[r][1];
				d.win[r][1] = q.win[r][0];
			end
			d.win[0][0] = line0;
			d.win[1][0] = line1;
			d.win[2][0] = q.ram_b[q.ptr];
		end

		// secondary bus direction, input from reset until software sets it
		d.po.pixel_io_secondary_oe = cso;
		d.po.pixel_io_secondary    = q.ram_b[q.ptr][7:0];

		// expansion halves: upper on phase 0, lower on the other phase
		if (!q.single && !q.master) begin
			if (!q.phase) begin
				d.exp_hi = p.coef_expansion_bus;
			end else begin
				d.expn = {q.exp_hi, p.coef_expansion_bus};
			end
		end

		// weighted window sum
		for (int r = 0; r < 3; r++) begin
			for (int c = 0; c < 3; c++) begin
				op = c16 ? {q.win[r][c][15], q.win[r][c]}
				         : {9'h000, q.win[r][c][7:0]};
				prod = $signed({{15{op[16]}}, op})
				     * $signed({{24{q.cfg[r*3+c][7]}}, q.cfg[r*3+c]});
				acc = acc + prod;
			end
		end
		if (!q.single && !q.master) begin
			acc = acc + $signed(q.expn);
		end
		if (pix_en) begin
			d.sum = acc;
		end

		// gain, saturation and threshold
		wide   = {{32{q.sum[31]}}, q.sum} << q.cfg[`IDX_GAIN][4:0];
		ovf    = ~(&wide[63:31] | ~|wide[63:31]);
		scaled = ovf ? (q.sum[31] ? 16'h8000 : 16'h7fff) : wide[31:16];
		if (pix_en) begin
			d.po.gain_saturation_flag = ovf;
			d.po.threshold_flag = $signed(scaled) > $signed(thr);
		end

		// result bus: scaled word, or lower then upper half of the sum
		if (q.cfg[`IDX_CTRL][`CTRL_INTER]) begin
			d.po.result_half_lo = ~q.phase;
			d.po.result_out = q.phase ? q.sum[31:16] : q.sum[15:0];
		end else begin
			d.po.result_half_lo = 1'b0;                      // no stale half flag
			if (pix_en) begin
				d.po.result_out = scaled;
			end
		end
		d.po.result_oe = ~p.output_drive_enable_n;

		// delayed copy of line sync
		if (pix_en) begin
			d.dly = {q.dly[14:0], p.line_sync_reset};
			d.po.delayed_sync_out = q.dly[q.cfg[`IDX_DELAY][3:0]];
		end

		// automatic field choice on long sync pulses
		if (pix_en) begin
			if (!p.line_sync_reset) begin
				d.sync_len = '0;
			end else if (q.sync_len != `VSYNC_PIX) begin
				d.sync_len = q.sync_len + 8'h01;
				if (q.sync_len == `VSYNC_PIX - 8'h01) begin
					d.field = ~q.field;
				end
			end
		end
		if (q.cfg[`IDX_CTRL][`CTRL_FLD_HI:`CTRL_FLD_LO] == `FIELD_AUTO) begin
			d.po.field_select_out = q.field ? `FIELD_B : `FIELD_A;
		end else begin
			d.po.field_select_out = q.cfg[`IDX_CTRL][`CTRL_FLD_HI:`CTRL_FLD_LO];
		end

		// strobe edge detectors on synchronised pins
		d.ds_prev = p.data_strobe_n;
		d.ce_prev = p.chip_enable_n;

		// host access over the pins when no eprom is used
		d.po.coef_expansion_oe = '0;
		if (q.strap_ok && !q.eprom) begin
			host_sel = ~p.chip_enable_n & p.reg_update_flag;
			if (host_sel && q.ds_prev && !p.data_strobe_n && !p.read_write
			    && haddr[6:4] == 3'h0) begin
				d.cfg[haddr[3:0]] = p.coef_expansion_bus[7:0];
			end
			if (host_sel && p.read_write && !p.data_strobe_n) begin
				d.po.coef_expansion_oe  = `BUS_DATA_OE;
				d.po.coef_expansion_bus = {8'h00, q.cfg[haddr[3:0]]};
			end
		end

		// a chip enable falling edge restarts an eprom load
		if (q.eprom && q.ce_prev && !p.chip_enable_n) begin
			start = 1'b1;
		end

		// eprom load sequence
		unique case (q.lst)
			LD_IDLE: begin
				if (start) begin
					d.lst   = LD_ADDR;
					d.laddr = '0;
					d.dev   = '0;
				end
			end
			LD_ADDR: begin
				d.lst  = LD_STRB;
				d.lcnt = '0;
			end
			LD_STRB: begin
				d.lcnt = q.lcnt + 3'h1;
				strb_end = q.master ? p.reg_update_flag_strobe_in
				                    : (q.lcnt == `STRB_LAST);
				if (strb_end) begin
					d.lst = LD_NEXT;
					if (q.dev == 4'h0 && q.laddr[6:4] == 3'h0) begin
						d.cfg[q.laddr[3:0]] = p.coef_expansion_bus[7:0];
					end
				end
			end
			LD_NEXT: begin
				d.lst = LD_ADDR;
				d.laddr = q.laddr + 7'h01;
				if (q.laddr == `LOAD_LAST) begin
					d.laddr = '0;
					d.dev = q.dev + 4'h1;
					if (!q.master || q.dev == `DEV_LAST) begin
						d.lst = LD_IDLE;
					end
				end
			end
			default: begin
				d.lst = LD_IDLE;
			end
		endcase

		// loader pins, driven from the next loader state
		if (q.eprom) begin
			d.po.reg_update_oe   = 1'b1;
			d.po.reg_update_flag = (d.lst != LD_IDLE);
			d.po.data_strobe_oe  = 1'b1;
			d.po.data_strobe_n   = (d.lst != LD_STRB);
			d.po.device_select_addr = d.dev;
			if (d.lst != LD_IDLE) begin
				d.po.coef_expansion_oe  = `BUS_ADDR_OE;
				d.po.coef_expansion_bus = {1'b0, d.laddr, 8'h00};
			end
		end else begin
			d.po.reg_update_oe   = 1'b0;
			d.po.reg_update_flag = 1'b0;
			d.po.data_strobe_oe  = 1'b0;
			d.po.data_strobe_n   = 1'b1;
		end

		// programming strobe: an eprom master makes it, all others pass it on
		if (q.master && q.eprom) begin
			d.po.reg_update_flag_strobe_out = (d.lst == LD_STRB);
		end else begin
			d.po.reg_update_flag_strobe_out = p.reg_update_flag_strobe_in;
		end

		// axi4-lite response handshakes
		if (q.rsp.bvalid && axi_req.bready) begin
			d.rsp.bvalid = 1'b0;
		end
		if (q.rsp.rvalid && axi_req.rready) begin
			d.rsp.rvalid = 1'b0;
		end

		// axi4-lite write address and data, taken in either order
		if (axi_req.awvalid && q.rsp.awready) begin
			d.aw_have = 1'b1;
			d.awaddr  = axi_req.awaddr;
		end
		if (axi_req.wvalid && q.rsp.wready) begin
			d.w_have = 1'b1;
			d.wbyte  = axi_req.wdata[7:0];
			d.wlane  = axi_req.wstrb[0];
		end
		if (q.aw_have && q.w_have && !q.rsp.bvalid) begin
			d.aw_have    = 1'b0;
			d.w_have     = 1'b0;
			d.rsp.bvalid = 1'b1;
			d.rsp.bresp  = `RESP_OKAY;
			if (widx < 6'(`CFG_N)) begin
				if (q.wlane) begin
					d.cfg[widx[3:0]] = q.wbyte;
				end
			end else if (widx != `IDX_STATUS) begin
				d.rsp.bresp = `RESP_SLVERR;
			end
		end
		d.rsp.awready = ~d.aw_have & ~d.rsp.bvalid;
		d.rsp.wready  = ~d.w_have & ~d.rsp.bvalid;

		// axi4-lite read
		if (axi_req.arvalid && q.rsp.arready) begin
			d.rsp.rvalid = 1'b1;
			d.rsp.rresp  = `RESP_OKAY;
			d.rsp.rdata  = '0;
			if (ridx < 6'(`CFG_N)) begin
				d.rsp.rdata = {24'h000000, q.cfg[ridx[3:0]]};
			end else if (ridx == `IDX_STATUS) begin
				d.rsp.rdata = {24'h000000, (q.lst != LD_IDLE), q.field,
				               q.po.gain_saturation_flag, q.po.threshold_flag,
				               q.eprom, q.master, q.single, q.strap_ok};
			end else begin
				d.rsp.rresp = `RESP_SLVERR;
			end
		end
		d.rsp.arready = ~d.rsp.rvalid;
	end

	// state register, synchronous active-low reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q                  <= '0;
			q.lst              <= LD_IDLE;
			q.ds_prev          <= 1'b1;
			q.ce_prev          <= 1'b1;
			q.po.data_strobe_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

endmodule : image_convolver_interface
`default_nettype wire

/* bench/conv_chk.sv */
// port checker for the convolver
`timescale 1ns/1ps
`default_nettype none
`include "conv_params.svh"
module conv_chk (
	// clock and reset
	input wire logic                aclk,
	input wire logic                aresetn,
	// register bus
	input wire conv_pkg::axi_req_t  axi_req,
	input wire conv_pkg::axi_rsp_t  axi_rsp,
	// device pins
	input wire conv_pkg::pins_in_t  pins_in,
	input wire conv_pkg::pins_out_t pins_out
);
	import conv_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// pins quiet right after reset
	a_reset_quiet: assert property (
		$rose(aresetn) |-> !pins_out.result_oe && !pins_out.pixel_io_secondary_oe
		&& pins_out.data_strobe_n && pins_out.coef_expansion_oe == 16'h0000)
		else $error("pins active after reset");
	// drivers off once enable held high
	a_drive_off: assert property (
		pins_in.output_drive_enable_n [*5] |-> !pins_out.result_oe)
		else $error("result driven while disabled");
	// loader stays in the low 72 addresses
	a_load_range: assert property (
		|pins_out.coef_expansion_oe[14:8] |-> pins_out.coef_expansion_bus[14:8] <= 7'h47)
		else $error("loader address out of range");
	// expansion bus drive shapes
	a_bus_shape: assert property (
		pins_out.coef_expansion_oe inside {16'h0000, `BUS_ADDR_OE, `BUS_DATA_OE})
		else $error("odd expansion bus enable");
	// strobe only while driving it during a load
	a_strobe_load: assert property (
		!pins_out.data_strobe_n |-> pins_out.data_strobe_oe && pins_out.reg_update_oe
		&& pins_out.reg_update_flag)
		else $error("strobe outside a load");
	// intermediate halves alternate
	a_half_alt: assert property (
		pins_out.result_half_lo |=> !pins_out.result_half_lo)
		else $error("low half held twice");
	// write answer two edges after both taken: halves caught, then answer raised
	a_write_resp: assert property (
		axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
		|-> ##2 axi_rsp.bvalid)
		else $error("write answer late");
	// read answer one cycle after address, upper bits zero
	a_read_resp: assert property (
		axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && axi_rsp.rdata[31:8] == 24'h0)
		else $error("read answer wrong");
	// main scenarios
	c_load: cover property (!pins_out.data_strobe_n);
	c_err: cover property (axi_rsp.bvalid && axi_rsp.bresp == `RESP_SLVERR);
	c_half: cover property (pins_out.result_half_lo);
endmodule : conv_chk
`default_nettype wire

/* bench/eprom_model.sv */
// eprom stand-in answering the coefficient loader
`timescale 1ns/1ps
`default_nettype none
module eprom_model (
	// clock
	input  wire logic                aclk,
	// device pins and answer speed
	input  wire conv_pkg::pins_out_t po,
	input  wire logic                slow,
	// data lines back
	output logic [7:0]               q
);
	import conv_pkg::*;
	logic [6:0] a_q;
	logic [7:0] last_q;
	logic       addr_on;
	logic       strb_on;
	// address driven or strobe asserted
	assign addr_on = |po.coef_expansion_oe[14:8];
	assign strb_on = po.data_strobe_oe && !po.data_strobe_n;
	// latch address, keep last byte
	initial last_q = 8'h00;
	always @(posedge aclk) begin
		if (addr_on)
			a_q <= po.coef_expansion_bus[14:8];
		last_q <= q;
	end
	// byte is address xor a5; released lines toggle
	always_comb begin
		if (addr_on && !slow)
			q = {1'b0, po.coef_expansion_bus[14:8]} ^ 8'ha5;
		else if (strb_on)
			q = {1'b0, a_q} ^ 8'ha5;
		else
			q = ~last_q;
	end
endmodule : eprom_model
`default_nettype wire

/* bench/tb_top.sv */
// testbench for the image convolver
`timescale 1ns/1ps
`default_nettype none
`include "conv_params.svh"
module tb_top;
	import conv_pkg::*;
	logic        aclk;
	logic        aresetn;
	axi_req_t    req;
	axi_rsp_t    rsp;
	pins_in_t    drv;
	pins_in_t    pin;
	pins_out_t   po;
	logic [7:0]  ep_q;
	logic        slow;
	logic [31:0] rnd;
	logic [7:0]  v[16];
	logic [1:0]  wq[$];
	logic [65:0] rq[$];
	int          failures;
	int          check_count;

	image_convolver_interface u_image_convolver_interface (.aclk(aclk), .aresetn(aresetn),
		.axi_req(req), .axi_rsp(rsp), .pins_in(pin), .pins_out(po));
	eprom_model u_eprom_model (.aclk(aclk), .po(po), .slow(slow), .q(ep_q));

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	function automatic logic [7:0] msk(input int i);
		return (i == 9) ? 8'h37 : (i == 10) ? 8'h1f : (i == 13) ? 8'h0f : 8'hff;
	endfunction : msk

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict

	// one bus transfer; expectation queued for the monitor
	task automatic xfer(input bit wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] e, input logic [31:0] m);
		bit ta;
		bit tw;
		bit tc;
		bit tr;
		int n;
		if (wr)
			wq.push_back(e);
		else
			rq.push_back({e, m, d & m});
		req.awaddr <= a;
		req.araddr <= a;
		req.wdata <= d;
		req.wstrb <= s;
		req.awvalid <= wr;
		req.wvalid <= wr;
		req.bready <= wr;
		req.arvalid <= !wr;
		req.rready <= !wr;
		n = 0;
		tr = 0;
		while (!tr && n < 200) begin
			@(negedge aclk);
			ta = req.awvalid && rsp.awready;
			tw = req.wvalid && rsp.wready;
			tc = req.arvalid && rsp.arready;
			tr = (req.bready && rsp.bvalid) || (req.rready && rsp.rvalid);
			@(posedge aclk);
			if (ta)
				req.awvalid <= 1'b0;
			if (tw)
				req.wvalid <= 1'b0;
			if (tc)
				req.arvalid <= 1'b0;
			n++;
		end
		req.bready <= 1'b0;
		req.rready <= 1'b0;
		chk("bus answer", tr, 1);
		@(posedge aclk);
	endtask : xfer

	task automatic rst;
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (8) @(posedge aclk);
	endtask : rst

	task automatic wait_load(input logic lv);
		int n;
		n = 0;
		while (po.reg_update_flag !== lv && n < 3000) begin
			@(negedge aclk);
			n++;
		end
		chk("load flag", po.reg_update_flag, lv);
		@(posedge aclk);
	endtask : wait_load

	// clock
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// wire level of two-way pins
	always_comb begin
		pin = drv;
		pin.pixel_io_secondary = po.pixel_io_secondary_oe ? po.pixel_io_secondary
			: drv.pixel_io_secondary;
		pin.data_strobe_n = po.data_strobe_oe ? po.data_strobe_n : drv.data_strobe_n;
		pin.reg_update_flag = po.reg_update_oe ? po.reg_update_flag : drv.reg_update_flag;
		pin.coef_expansion_bus = (po.coef_expansion_oe & po.coef_expansion_bus)
			| (~po.coef_expansion_oe & {drv.coef_expansion_bus[15:8],
			drv.coef_expansion_bus[15] ? ep_q : drv.coef_expansion_bus[7:0]});
	end

	// random pixel and expansion source
	always @(posedge aclk) begin
		rnd <= lfsr(rnd);
		drv.pixel_in_primary <= rnd[7:0];
		drv.pixel_io_secondary <= rnd[15:8];
		drv.bypass <= rnd[31];
		drv.coef_expansion_bus[14:0] <= rnd[30:16];
	end

	// monitor pops expectations at each answer
	always @(negedge aclk) begin
		logic [65:0] y;
		if (req.bready && rsp.bvalid)
			chk("bresp", rsp.bresp, wq.pop_front());
		if (req.rready && rsp.rvalid) begin
			y = rq.pop_front();
			chk("rresp", rsp.rresp, y[65:64]);
			chk("rdata", rsp.rdata & y[63:32], y[31:0]);
		end
	end

	// watchdog
	initial begin
		repeat (20000) @(posedge aclk);
		failures++;
		give_verdict();
	end

	// main sequence
	initial begin
		rnd = 32'ha798fae3;
		req = '0;
		drv = '0;
		drv.data_strobe_n = 1'b1;
		drv.chip_enable_n = 1'b1;
		drv.single_n = 1'b1;
		drv.master_n = 1'b1;
		slow = 1'b0;
		aresetn = 1'b0;
		failures = 0;
		check_count = 0;
		rst();
		xfer(0, 8'h40, 32'h01, 4'h0, `RESP_OKAY, 32'h8f);
		for (int i = 0; i < 16; i++)
			xfer(0, 8'(i * 4), 32'h0, 4'h0, `RESP_OKAY, 32'hffffffff);
		$display("reset values done");
		for (int i = 0; i < 16; i++) begin
			v[i] = rnd[7:0];
			xfer(1, 8'(i * 4), {24'h0, v[i]}, 4'hf, `RESP_OKAY, 0);
			xfer(0, 8'(i * 4), {24'h0, v[i]}, 4'h0, `RESP_OKAY, {24'hffffff, msk(i)});
		end
		xfer(1, 8'h00, 32'h5a, 4'h0, `RESP_OKAY, 0);
		xfer(0, 8'h00, {24'h0, v[0]}, 4'h0, `RESP_OKAY, 32'hffffffff);
		xfer(1, 8'h40, 32'hff, 4'hf, `RESP_OKAY, 0);
		xfer(0, 8'h40, 32'h01, 4'h0, `RESP_OKAY, 32'h0f);
		xfer(1, 8'h44, 32'h1, 4'hf, `RESP_SLVERR, 0);
		xfer(0, 8'h80, 32'h0, 4'h0, `RESP_SLVERR, 0);
		$display("register access done");
		for (int m = 1; m < 4; m++) begin
			xfer(1, 8'h24, {26'h0, 2'(m), 4'h0}, 4'hf, `RESP_OKAY, 0);
			repeat (8) @(posedge aclk);
			// auto mode shows field a while no long sync has been seen
			chk("field", po.field_select_out, (m < 3) ? m : `FIELD_A);
		end
		xfer(1, 8'h24, 32'h02, 4'hf, `RESP_OKAY, 0);
		repeat (4) @(posedge aclk);
		chk("secondary oe", po.pixel_io_secondary_oe, 1);
		xfer(1, 8'h24, 32'h04, 4'hf, `RESP_OKAY, 0);
		repeat (4) @(posedge aclk);
		chk("secondary off", po.pixel_io_secondary_oe, 0);
		@(negedge aclk);
		v[1][0] = po.result_half_lo;
		@(negedge aclk);
		chk("half", po.result_half_lo, !v[1][0]);
		@(posedge aclk);
		drv.output_drive_enable_n <= 1'b1;
		drv.reg_update_flag_strobe_in <= 1'b1;
		repeat (6) @(posedge aclk);
		chk("drive off", po.result_oe, 0);
		chk("strobe pass", po.reg_update_flag_strobe_out, 1);
		drv.output_drive_enable_n <= 1'b0;
		drv.reg_update_flag_strobe_in <= 1'b0;
		repeat (6) @(posedge aclk);
		chk("drive on", po.result_oe, 1);
		chk("strobe idle", po.reg_update_flag_strobe_out, 0);
		xfer(1, 8'h34, 32'h03, 4'hf, `RESP_OKAY, 0);
		repeat (40) @(posedge aclk);
		chk("sync low", po.delayed_sync_out, 0);
		drv.line_sync_reset <= 1'b1;
		repeat (40) @(posedge aclk);
		chk("sync high", po.delayed_sync_out, 1);
		drv.line_sync_reset <= 1'b0;
		$display("pin modes done");
		drv.single_n <= 1'b0;
		drv.coef_expansion_bus[15] <= 1'b1;
		rst();
		wait_load(1);
		chk("device select", po.device_select_addr, 0);
		wait_load(0);
		xfer(0, 8'h40, 32'h0b, 4'h0, `RESP_OKAY, 32'h8f);
		for (int i = 0; i < 9; i++)
			xfer(0, 8'(i * 4), 32'(i) ^ 32'ha5, 4'h0, `RESP_OKAY, 32'hffffffff);
		slow <= 1'b1;
		drv.chip_enable_n <= 1'b0;
		wait_load(1);
		drv.chip_enable_n <= 1'b1;
		wait_load(0);
		$display("eprom load done");
		give_verdict();
	end
endmodule : tb_top

bind image_convolver_interface conv_chk u_conv_chk (.aclk(aclk), .aresetn(aresetn),
	.axi_req(axi_req), .axi_rsp(axi_rsp), .pins_in(pins_in), .pins_out(pins_out));
`default_nettype wire
